// [logic/drive_status_output_logic.sv]
`default_nettype none
module drive_status_output_logic #(
  parameter int N_OUT = 5
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  input  wire status_out_pkg::wb_req_t       wb_req,
  output var  status_out_pkg::wb_rsp_t       wb_rsp,
  input  wire status_out_pkg::drive_in_t     drv,
  output var  logic [N_OUT-1:0]              out_level,
  output var  logic                          accel_enable
);
  import status_out_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {BRK_IDLE, BRK_WAIT, BRK_RUN, BRK_STOP} brk_st_t;

  typedef struct packed {
    freq_t              thresh;
    freq_t              delta;
    logic [HYST_W-1:0]  hyst;
    logic [BRK_W-1:0]   brake_t;
    stop_t              stop_code;
    logic [N_OUT-1:0][7:0] mode;
    logic               set_f;
    logic               ref_f_hit;
    logic               ref_p_hit;
    logic               flux;
    logic               brake;
    brk_st_t            brk_st;
    logic [BRK_W-1:0]   brk_cnt;
    logic               accel;
    logic [N_OUT-1:0]   outs;
    logic               ack;
    logic [31:0]        rdat;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // Off level and hysteresis bands
  freq_t        off_lvl;
  freq_t        hyst_f;
  logic [15:0]  hyst_p;
  logic [31:0]  prod_f;
  logic [31:0]  prod_p;
  logic [FREQ_W:0] sum_f;
  logic [16:0]  sum_p;
  logic         wb_hit;
  logic         wb_wr;
  logic         ilim_mask;
  logic         stop_hold;
  logic         stop_drop;

  // ****************************************************************
  // Combinational helpers
  // ****************************************************************
  always_comb begin
    off_lvl = (st_r.delta > st_r.thresh) ? '0 : freq_t'(st_r.thresh - st_r.delta);
    prod_f  = 32'(drv.range_f) * 32'(st_r.hyst);
    hyst_f  = freq_t'(prod_f / 32'(PCT_DIV));
    prod_p  = 32'h0000_2710 * 32'(st_r.hyst); // 100.00 % range
    hyst_p  = 16'(prod_p / 32'(PCT_DIV));
    sum_f   = {1'b0, drv.stator_f} + {1'b0, hyst_f};
    sum_p   = {1'b0, drv.act_pct} + {1'b0, hyst_p};
    wb_hit  = wb_req.cyc && wb_req.stb && !st_r.ack;
    wb_wr   = wb_req.cyc && wb_req.stb && wb_req.we && st_r.ack;
    ilim_mask = drv.sensorless && !drv.ilim_enable;
    // Brake drop on stop: code zero at once, holding codes never, the rest at switch-off or hold end
    stop_hold = (st_r.stop_code == STOP_HOLD_A) || (st_r.stop_code == STOP_HOLD_B);
    stop_drop = (st_r.stop_code == STOP_IMMEDIATE) || (!stop_hold && (drv.off_reached || drv.hold_over));
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;

    // Wishbone slave: one wait state, ack for one cycle
    if (wb_hit) begin
      st_nxt.ack  = 1'b1;
      st_nxt.rdat = '0;
      unique case (wb_req.adr)
        REG_THRESH:  st_nxt.rdat = 32'(st_r.thresh);
        REG_DELTA:   st_nxt.rdat = 32'(st_r.delta);
        REG_HYST:    st_nxt.rdat = 32'(st_r.hyst);
        REG_BRAKE_T: st_nxt.rdat = 32'(st_r.brake_t);
        REG_STOP:    st_nxt.rdat = 32'(st_r.stop_code);
        REG_MODE_LO: st_nxt.rdat = {st_r.mode[3], st_r.mode[2], st_r.mode[1], st_r.mode[0]};
        REG_MODE_HI: st_nxt.rdat = 32'(st_r.mode[4]);
        REG_STATUS:  st_nxt.rdat = {20'h00000, st_r.accel, st_r.brake, st_r.flux, st_r.ref_p_hit,
                                    st_r.ref_f_hit, st_r.set_f, 1'b0, st_r.outs};
        default:     st_nxt.rdat = '0;
      endcase
    end

    // Writes land at the edge where the master samples ack high
    if (wb_wr) begin
        unique case (wb_req.adr)
          REG_THRESH:
            if (&wb_req.sel[2:0] && wb_req.dat[FREQ_W-1:0] <= THRESH_MAX)
              st_nxt.thresh = wb_req.dat[FREQ_W-1:0];
          REG_DELTA:
            if (&wb_req.sel[2:0] && wb_req.dat[FREQ_W-1:0] <= THRESH_MAX)
              st_nxt.delta = wb_req.dat[FREQ_W-1:0];
          REG_HYST:
            if (wb_req.sel[0] && wb_req.dat[6:0] <= PCT_DIV)
              st_nxt.hyst = wb_req.dat[HYST_W-1:0];
          REG_BRAKE_T:
            if (&wb_req.sel[1:0])
              st_nxt.brake_t = wb_req.dat[BRK_W-1:0];
          REG_STOP:
            if (wb_req.sel[0])
              st_nxt.stop_code = wb_req.dat[2:0];
          REG_MODE_LO: begin
            for (int i = 0; i < 4; i++) begin
              if (wb_req.sel[i] && i < N_OUT)
                st_nxt.mode[i] = wb_req.dat[8*i +: 8];
            end
          end
          REG_MODE_HI:
            if (wb_req.sel[0] && N_OUT > 4)
              st_nxt.mode[4] = wb_req.dat[7:0];
          default: ;
        endcase
    end

    // Conditions evaluated once per control update
    if (drv.update) begin
      // Threshold frequency with switch-off hysteresis
      if (!drv.stage_on)
        st_nxt.set_f = 1'b0;
      else if (drv.stator_f > st_r.thresh)
        st_nxt.set_f = 1'b1;
      else if (drv.stator_f < off_lvl)
        st_nxt.set_f = 1'b0;

      // Reference reached: set on reach, clear beyond the band
      if (drv.stator_f >= drv.ref_f)
        st_nxt.ref_f_hit = 1'b1;
      else if (sum_f < {1'b0, drv.ref_f})
        st_nxt.ref_f_hit = 1'b0;
      if (drv.act_pct >= drv.ref_pct)
        st_nxt.ref_p_hit = 1'b1;
      else if (sum_p < {1'b0, drv.ref_pct})
        st_nxt.ref_p_hit = 1'b0;

      st_nxt.flux = drv.flux_done && drv.stage_on;

      // Brake release sequence
      unique case (st_r.brk_st)
        BRK_IDLE: begin
          st_nxt.brake = 1'b0;
          st_nxt.accel = 1'b0;
          if (drv.run_cmd && drv.flux_done && !drv.coasting) begin
            st_nxt.brake   = 1'b1;
            st_nxt.brk_cnt = '0;
            st_nxt.brk_st  = BRK_WAIT;
          end
        end
        BRK_WAIT: begin
          // Counts in update strobes; acceleration held until release time
          if (!drv.run_cmd) begin
            // A stop inside the release wait must not leave the brake open
            st_nxt.accel  = 1'b0;
            st_nxt.brk_st = BRK_STOP;
            if (stop_drop) begin
              st_nxt.brake  = 1'b0;
              st_nxt.brk_st = BRK_IDLE;
            end
          end else if (st_r.brk_cnt >= st_r.brake_t) begin
            st_nxt.accel  = 1'b1;
            st_nxt.brk_st = BRK_RUN;
          end else begin
            st_nxt.brk_cnt = st_r.brk_cnt + 1'b1;
          end
        end
        BRK_RUN:
          if (!drv.run_cmd) begin
            st_nxt.accel  = 1'b0;
            st_nxt.brk_st = BRK_STOP;
            if (stop_drop) begin
              st_nxt.brake  = 1'b0;
              st_nxt.brk_st = BRK_IDLE;
            end
          end
        BRK_STOP: begin
          if (drv.run_cmd) begin
            st_nxt.brk_st = BRK_RUN;
            st_nxt.accel  = 1'b1;
          end else if (stop_hold) begin
            st_nxt.brake = 1'b1;
          end else if (stop_drop) begin
            // Holding time end is a backstop: brake drops inside the hold
            st_nxt.brake  = 1'b0;
            st_nxt.brk_st = BRK_IDLE;
          end
        end
      endcase
      // Coasting overrides every stop behaviour
      if (drv.coasting) begin
        st_nxt.brake  = 1'b0;
        st_nxt.accel  = 1'b0;
        st_nxt.brk_st = BRK_IDLE;
      end
    end

    // Output routing per selector, registered
    for (int i = 0; i < N_OUT; i++) begin
      st_nxt.outs[i] = 1'b0;
      if (st_r.mode[i][7:6] == 2'b00) begin
        unique case (st_r.mode[i][5:0])
          MODE_SET_FREQ:  st_nxt.outs[i] = st_r.set_f;
          MODE_REF_FREQ:  st_nxt.outs[i] = st_r.ref_f_hit;
          MODE_REF_PCT:   st_nxt.outs[i] = st_r.ref_p_hit;
          MODE_FLUX_DONE: st_nxt.outs[i] = st_r.flux;
          MODE_BRAKE:     st_nxt.outs[i] = st_r.brake;
          default:
            if (st_r.mode[i][5:0] >= MODE_ILIM_FIRST && st_r.mode[i][5:0] <= MODE_ILIM_LAST) begin
              st_nxt.outs[i] = drv.ilim_evt[3'(st_r.mode[i][5:0] - MODE_ILIM_FIRST)];
              if (ilim_mask && st_r.mode[i][5:0] >= MODE_ILIM_SENS)
                st_nxt.outs[i] = 1'b0;
            end
        endcase
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r           <= '0;
      st_r.thresh    <= THRESH_RESET;
      st_r.delta     <= DELTA_RESET;
      st_r.hyst      <= HYST_RESET;
      st_r.brake_t   <= BRAKE_T_RESET;
      st_r.stop_code <= STOP_IMMEDIATE;
      st_r.brk_st    <= BRK_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  always_comb begin
    out_level    = st_r.outs;
    accel_enable = st_r.accel;
    wb_rsp.ack   = st_r.ack;
    wb_rsp.dat   = st_r.rdat;
  end

endmodule
`default_nettype wire

// [shared/status_out_pkg.sv]
`default_nettype none
package status_out_pkg;

  // ****************************************************************
  // Frequency values: unsigned, 0.01 Hz per count
  // ****************************************************************
  localparam int FREQ_W = 17;
  typedef logic [FREQ_W-1:0] freq_t;
  localparam freq_t THRESH_MAX   = 17'h1869f; // 999.99 Hz
  localparam freq_t THRESH_RESET = 17'h0012c; // 3.00 Hz
  localparam freq_t DELTA_RESET  = 17'h000c8; // 2.00 Hz

  // ****************************************************************
  // Output mode codes
  // ****************************************************************
  localparam int MODE_W = 6;
  typedef logic [MODE_W-1:0] mode_t;
  localparam mode_t MODE_OFF        = 6'h00;
  localparam mode_t MODE_SET_FREQ   = 6'h04;
  localparam mode_t MODE_REF_FREQ   = 6'h05;
  localparam mode_t MODE_REF_PCT    = 6'h06;
  localparam mode_t MODE_ILIM_FIRST = 6'h0f;
  localparam mode_t MODE_ILIM_SENS  = 6'h10;
  localparam mode_t MODE_ILIM_LAST  = 6'h13;
  localparam mode_t MODE_FLUX_DONE  = 6'h1e;
  localparam mode_t MODE_BRAKE      = 6'h29;
  localparam int    ILIM_N          = 5;

  // ****************************************************************
  // Stopping behaviour codes
  // ****************************************************************
  typedef logic [2:0] stop_t;
  localparam stop_t STOP_IMMEDIATE = 3'h0;
  localparam stop_t STOP_HOLD_A    = 3'h2;
  localparam stop_t STOP_HOLD_B    = 3'h5;

  // ****************************************************************
  // Register bus map (word addresses are byte offsets)
  // ****************************************************************
  localparam int ADR_W = 8;
  typedef logic [ADR_W-1:0] adr_t;
  localparam adr_t REG_THRESH   = 8'h00;
  localparam adr_t REG_DELTA    = 8'h04;
  localparam adr_t REG_HYST     = 8'h08;
  localparam adr_t REG_BRAKE_T  = 8'h0c;
  localparam adr_t REG_STOP     = 8'h10;
  localparam adr_t REG_MODE_LO  = 8'h14;
  localparam adr_t REG_MODE_HI  = 8'h18;
  localparam adr_t REG_STATUS   = 8'h1c;
  localparam int   HYST_W       = 7;
  localparam logic [HYST_W-1:0] HYST_RESET = 7'h05; // percent
  localparam logic [6:0] PCT_DIV = 7'h64;           // 100 percent
  localparam int   BRK_W        = 16;
  localparam logic [BRK_W-1:0] BRAKE_T_RESET = 16'h0000;

  // Classic Wishbone slave signals
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    adr_t        adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // Control-loop values from the drive controller
  typedef struct packed {
    logic              update;    // One-cycle control strobe
    freq_t             stator_f;
    freq_t             ref_f;
    freq_t             range_f;   // Max minus min of frequency range
    logic [15:0]       act_pct;   // 0.01 % per count
    logic [15:0]       ref_pct;
    logic              stage_on;
    logic              flux_done;
    logic              run_cmd;
    logic              coasting;
    logic              off_reached;  // Switch-off threshold reached
    logic              hold_over;    // End of holding time
    logic              sensorless;
    logic              ilim_enable;
    logic [ILIM_N-1:0] ilim_evt;
  } drive_in_t;

endpackage
`default_nettype wire

// [sim/brake_load_model.sv]
`default_nettype none
module brake_load_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic release_cmd,
  output var  logic engaged
);
  timeunit 1ns;
  timeprecision 1ns;
  // Spring-applied brake falls in as soon as the coil drops; one clock of armature lag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      engaged <= 1'b1;
    end else begin
      engaged <= !release_cmd;
    end
  end
endmodule
`default_nettype wire

// [sim/drive_status_output_logic_checker.sv]
`default_nettype none
module drive_status_output_logic_checker import status_out_pkg::*; #(
  parameter int N_OUT = 5
) (
  input wire logic                      clk_sys,
  input wire logic                      rst_n,
  input wire status_out_pkg::wb_req_t   wb_req,
  input wire status_out_pkg::wb_rsp_t   wb_rsp,
  input wire status_out_pkg::drive_in_t drv,
  input wire logic [N_OUT-1:0]          out_level,
  input wire logic                      accel_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mlo_r;
  mode_t       mhi_r;
  freq_t       thr_r;
  freq_t       dlt_r;
  stop_t       st_r;
  freq_t       off;
  logic        wr;
  // Shadow settings follow acked writes only; out-of-range threshold values are refused
  assign wr  = wb_rsp.ack && wb_req.cyc && wb_req.stb && wb_req.we;
  assign off = (dlt_r > thr_r) ? '0 : thr_r - dlt_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mlo_r <= '0;
      mhi_r <= MODE_OFF;
      thr_r <= THRESH_RESET;
      dlt_r <= DELTA_RESET;
      st_r  <= STOP_IMMEDIATE;
    end else if (wr) begin
      if (wb_req.adr == REG_MODE_LO) mlo_r <= wb_req.dat;
      if (wb_req.adr == REG_MODE_HI) mhi_r <= wb_req.dat[5:0];
      if (wb_req.adr == REG_STOP) st_r <= wb_req.dat[2:0];
      if (wb_req.adr == REG_THRESH && wb_req.dat <= 32'h1869f) thr_r <= wb_req.dat[16:0];
      if (wb_req.adr == REG_DELTA && wb_req.dat <= 32'h1869f) dlt_r <= wb_req.dat[16:0];
    end
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Isolated evaluation strobe, so the result two edges on belongs to it alone
  sequence s_ev(c);
    c && drv.update ##1 !drv.update;
  endsequence
  property p_set_on;
    s_ev(mlo_r[5:0] == MODE_SET_FREQ && drv.stage_on && drv.stator_f > thr_r) |-> ##1 out_level[0];
  endproperty
  property p_set_off;
    s_ev(mlo_r[5:0] == MODE_SET_FREQ && drv.stator_f < off) |-> ##1 !out_level[0];
  endproperty
  property p_stage;
    s_ev(mlo_r[5:0] == MODE_SET_FREQ && !drv.stage_on) |-> ##1 !out_level[0];
  endproperty
  property p_flux;
    s_ev(mlo_r[5:0] == MODE_FLUX_DONE) |-> ##1 out_level[0] == $past(drv.flux_done && drv.stage_on, 2);
  endproperty
  property p_ilim_on;
    (mlo_r[13:8] == MODE_ILIM_FIRST && drv.ilim_evt[0])[*3] |-> out_level[1];
  endproperty
  property p_ilim_off;
    (mlo_r[21:16] == MODE_ILIM_SENS && drv.sensorless && !drv.ilim_enable)[*3] |-> !out_level[2];
  endproperty
  property p_brk_on;
    s_ev(mhi_r == MODE_BRAKE && drv.run_cmd && drv.flux_done && !drv.coasting) |-> ##1 out_level[4];
  endproperty
  property p_stop0;
    s_ev(mhi_r == MODE_BRAKE && st_r == STOP_IMMEDIATE && !drv.run_cmd) |-> ##1 !out_level[4];
  endproperty
  property p_hold;
    s_ev(mhi_r == MODE_BRAKE && (st_r == STOP_HOLD_A || st_r == STOP_HOLD_B) && out_level[4] && !drv.coasting)
      |-> ##1 out_level[4];
  endproperty
  property p_stop_off;
    s_ev(mhi_r == MODE_BRAKE && !drv.run_cmd && !drv.coasting && (drv.off_reached || drv.hold_over)
      && st_r != STOP_IMMEDIATE && st_r != STOP_HOLD_A && st_r != STOP_HOLD_B) |-> ##1 !out_level[4];
  endproperty
  property p_coast;
    s_ev(mhi_r == MODE_BRAKE && drv.coasting) |-> ##1 !out_level[4] && !accel_enable;
  endproperty
  a_set_on: assert property (p_set_on) else $error("threshold output missed a rise");
  a_set_off: assert property (p_set_off) else $error("threshold output held below off level");
  a_stage: assert property (p_stage) else $error("threshold output set with stage off");
  a_flux: assert property (p_flux) else $error("flux output wrong");
  a_ilim_on: assert property (p_ilim_on) else $error("limit event not routed");
  a_ilim_off: assert property (p_ilim_off) else $error("limit output active while disabled");
  a_brk_on: assert property (p_brk_on) else $error("brake not released after magnetizing");
  a_stop0: assert property (p_stop0) else $error("brake kept on stop code zero");
  a_hold: assert property (p_hold) else $error("brake dropped on holding stop code");
  a_stop_off: assert property (p_stop_off) else $error("brake kept past switch-off");
  a_coast: assert property (p_coast) else $error("brake or accel kept while coasting");
endmodule
bind drive_status_output_logic drive_status_output_logic_checker #(.N_OUT(N_OUT)) u_checker (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp), .drv(drv), .out_level(out_level),
  .accel_enable(accel_enable));
`default_nettype wire

// [sim/tb_drive_status_output_logic.sv]
`default_nettype none
module tb_drive_status_output_logic import status_out_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed { mode_t m; freq_t f; freq_t r; logic s; logic x; logic e; } row_t;
  logic        clk_sys;
  logic        rst_n;
  wb_req_t     wb_req;
  wb_rsp_t     wb_rsp;
  drive_in_t   drv;
  logic [4:0]  out_level;
  logic        accel_enable;
  logic        brk_engaged;
  logic [31:0] q;
  int          err_count;
  int          checks_done;
  // Rows run in order: threshold and reference rows lean on the previous flag state
  row_t rows [13] = '{
    '{MODE_SET_FREQ, 17'h12d, 17'h0, 1'b1, 1'b0, 1'b1}, '{MODE_SET_FREQ, 17'hc8, 17'h0, 1'b1, 1'b0, 1'b1},
    '{MODE_SET_FREQ, 17'h63, 17'h0, 1'b1, 1'b0, 1'b0}, '{MODE_SET_FREQ, 17'h12c, 17'h0, 1'b1, 1'b0, 1'b0},
    '{MODE_SET_FREQ, 17'h1f4, 17'h0, 1'b0, 1'b0, 1'b0}, '{MODE_FLUX_DONE, 17'h0, 17'h0, 1'b1, 1'b1, 1'b1},
    '{MODE_FLUX_DONE, 17'h0, 17'h0, 1'b0, 1'b1, 1'b0}, '{MODE_REF_FREQ, 17'h3e8, 17'h3e8, 1'b1, 1'b0, 1'b1},
    '{MODE_REF_FREQ, 17'h258, 17'h3e8, 1'b1, 1'b0, 1'b1}, '{MODE_REF_FREQ, 17'h190, 17'h3e8, 1'b1, 1'b0, 1'b0},
    '{MODE_REF_PCT, 17'h7d0, 17'h7d0, 1'b1, 1'b0, 1'b1}, '{MODE_REF_PCT, 17'h5dc, 17'h7d0, 1'b1, 1'b0, 1'b1},
    '{MODE_REF_PCT, 17'h5db, 17'h7d0, 1'b1, 1'b0, 1'b0}};
  adr_t        ra [7] = '{REG_THRESH, REG_DELTA, REG_HYST, REG_BRAKE_T, REG_STOP, REG_MODE_LO, 8'h20};
  logic [31:0] rv [7] = '{32'h12c, 32'hc8, 32'h5, 32'h0, 32'h0, 32'h0, 32'h0};
  drive_status_output_logic #(.N_OUT(5)) DUT (.clk_sys(clk_sys), .rst_n(rst_n), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .drv(drv), .out_level(out_level), .accel_enable(accel_enable));
  brake_load_model u_brake (.clk_sys(clk_sys), .rst_n(rst_n), .release_cmd(out_level[4]), .engaged(brk_engaged));
  always #20 clk_sys = ~clk_sys;
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Classic cycle; the wait is bounded so a silent slave ends the run
  task automatic bus(input logic w, input adr_t a, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: d};
    do begin
      @(posedge clk_sys);
      k++;
    end while (wb_rsp.ack !== 1'b1 && k < 20);
    q = wb_rsp.dat;
    wb_req <= '0;
    if (wb_rsp.ack !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
    @(posedge clk_sys);
  endtask
  task automatic rd(input adr_t a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(q, e, "register");
  endtask
  // Outputs land two edges after the strobe; four edges leave the brake model time to follow
  task automatic upd();
    drv.update <= 1'b1;
    @(posedge clk_sys);
    drv.update <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    wb_req = '0;
    drv = '0;
    drv.range_f = 17'h02710;
    err_count = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_sys);
    chk(out_level, 32'h0, "out_level in reset");
    chk(accel_enable, 32'h0, "accel in reset");
    rst_n <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 7; i++) begin
      rd(ra[i], rv[i]);
    end
    // Output 3 mirrors output 0 so every selector is seen
    for (int i = 0; i < 13; i++) begin
      bus(1'b1, REG_MODE_LO, {2'h0, rows[i].m, 2'h0, MODE_ILIM_SENS, 2'h0, MODE_ILIM_FIRST, 2'h0, rows[i].m}, 4'hf);
      drv.stator_f <= rows[i].f;
      drv.ref_f <= rows[i].r;
      drv.act_pct <= rows[i].f[15:0];
      drv.ref_pct <= rows[i].r[15:0];
      drv.stage_on <= rows[i].s;
      drv.flux_done <= rows[i].x;
      upd();
      chk(out_level[0], rows[i].e, "row output");
      chk(out_level[3], rows[i].e, "row output 3");
    end
    // Delta above threshold latches the output; only the stage can clear it
    bus(1'b1, REG_MODE_LO, {10'h0, MODE_ILIM_SENS, 2'h0, MODE_ILIM_FIRST, 2'h0, MODE_SET_FREQ}, 4'hf);
    bus(1'b1, REG_DELTA, 32'h190, 4'hf);
    drv.stage_on <= 1'b1;
    drv.stator_f <= 17'h190;
    upd();
    chk(out_level[0], 32'h1, "latch set");
    drv.stator_f <= 17'h0;
    upd();
    chk(out_level[0], 32'h1, "latch hold");
    drv.stage_on <= 1'b0;
    upd();
    chk(out_level[0], 32'h0, "latch stage off");
    bus(1'b1, REG_THRESH, 32'h186a0, 4'hf);
    rd(REG_THRESH, 32'h12c);
    bus(1'b1, REG_THRESH, 32'h1869f, 4'hf);
    rd(REG_THRESH, 32'h1869f);
    // Current-limit events on outputs 1 and 2
    drv.stage_on <= 1'b1;
    drv.ilim_enable <= 1'b1;
    drv.ilim_evt <= 5'h03;
    repeat (4) @(posedge clk_sys);
    chk(out_level[2:1], 32'h3, "limit routing");
    drv.sensorless <= 1'b1;
    drv.ilim_enable <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(out_level[2:1], 32'h1, "limit disabled");
    drv.ilim_evt <= 5'h00;
    // Brake on output 4 with the release time set to 3, so accel comes four strobes after release
    bus(1'b1, REG_MODE_HI, {26'h0, MODE_BRAKE}, 4'hf);
    bus(1'b1, REG_BRAKE_T, 32'h3, 4'hf);
    drv.run_cmd <= 1'b1;
    drv.flux_done <= 1'b1;
    upd();
    chk(brk_engaged, 32'h0, "brake released");
    chk(accel_enable, 32'h0, "accel waits");
    repeat (5) upd();
    chk(accel_enable, 32'h1, "accel after release time");
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, REG_STOP, c, 4'h1);
      drv.run_cmd <= 1'b1;
      drv.off_reached <= 1'b0;
      drv.hold_over <= 1'b0;
      upd();
      drv.run_cmd <= 1'b0;
      upd();
      chk(brk_engaged, (c == 0), "brake on stop");
      drv.off_reached <= c[0];
      drv.hold_over <= !c[0];
      upd();
      chk(brk_engaged, !(c == 2 || c == 5), "brake at switch-off");
    end
    drv.run_cmd <= 1'b1;
    upd();
    drv.coasting <= 1'b1;
    upd();
    chk({brk_engaged, accel_enable}, 32'h2, "coasting");
    report_and_stop();
  end
endmodule
`default_nettype wire
